// File: rtl/ctp_defs.svh
// Purpose: Offsets, fields, resets and counts of the cascaded timer
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Behaviour
// Behaviour
// - Two 8-bit counters chained into one 16-bit up-counter on chosen clock.
// - Timer mode: once running, compare match raises interrupt, clears counter.
// - Period value applies at once; software leaves it alone while running.
// - Source clock high/2^11,2^7,2^5,2^3; low/8 replaces 2^11 or in slow mode.
// - PWM: toggle on duty match, toggle again on overflow, clear, interrupt.
// - Flip-flop loads from initial-value bit; reset clears it to 0.
// - PWM pin is the inverse of the flip-flop.
// - Duty written while running waits in shadow until the interrupt.
// - Duty written while stopped is transferred straight after the write.
// - Duty read during PWM shows the old value until the next interrupt.
// - Stop holds the pin; initial value changes only by a later write.
// - PWM also offers undivided low clock, high clock/2 and undivided high.
// - Upper control bit 3 is run, bit 7 is flip-flop initial value.
`ifndef CTP_DEFS_SVH
`define CTP_DEFS_SVH
`define CTP_OFF_LOW_CTRL 8'h00
`define CTP_OFF_HIGH_CTRL 8'h04
`define CTP_OFF_PER_LO 8'h08
`define CTP_OFF_PER_HI 8'h0C
`define CTP_OFF_DUTY_LO 8'h10
`define CTP_OFF_DUTY_HI 8'h14
`define CTP_OFF_COUNT 8'h18
`define CTP_RUN_BIT 3
`define CTP_INIT_BIT 7
`define CTP_MODE_LSB 0
`define CTP_CLK_LSB 4
`define CTP_MODE_TIMER 3'h4
`define CTP_MODE_PWM 3'h6
`define CTP_CTRL_RST 8'h00
`define CTP_CMP_RST 8'h00
`define CTP_LOWDIV_LAST 3'h7
`endif

// File: rtl/ctp_pkg.sv
// Purpose: Types of the cascaded timer
// Assumes: APB with 32-bit data
// Notes: Constants live in ctp_defs.svh
package ctp_pkg;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} ctp_apb_req_t;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ctp_apb_rsp_t;
	typedef enum logic [2:0] {
		CTP_SRC_DIV11,
		CTP_SRC_DIV7,
		CTP_SRC_DIV5,
		CTP_SRC_DIV3,
		CTP_SRC_LOW,
		CTP_SRC_DIV1,
		CTP_SRC_FULL,
		CTP_SRC_NONE
	} ctp_src_t;
endpackage : ctp_pkg

// File: rtl/ctp_timer.sv
// Purpose: Cascaded 16-bit interval timer and PWM generator
// Assumes: core_clk_i is the high clock, low clock arrives as a tick
// Notes: Zero-wait APB slave, outputs all registered
`include "ctp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ctp_timer #(
	parameter int CNT_W = 16,
	parameter int DIV_W = 11
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire ctp_pkg::ctp_apb_req_t apb_req_i,
	input wire logic low_freq_tick_i,
	input wire logic prescaler_source_select_i,
	input wire logic slow_mode_i,
	output ctp_pkg::ctp_apb_rsp_t apb_rsp_o,
	output logic cascade_match_irq_o,
	output logic pwm_out_pin_o
);

	// Refuse widths the byte registers cannot serve
	if (CNT_W != 16 || DIV_W != 11) begin : g_chk
		$error("ctp_timer: CNT_W must be 16, DIV_W 11");
	end

	logic [7:0] low_ctrl_r;
	logic [7:0] high_ctrl_r;
	logic [7:0] per_lo_r;
	logic [7:0] per_hi_r;
	logic [7:0] duty_lo_r;
	logic [7:0] duty_hi_r;
	logic [CNT_W-1:0] duty_act_r;
	logic [CNT_W-1:0] count_r;
	logic [DIV_W-1:0] div_r;
	logic [2:0] lowdiv_r;
	logic load_pend_r;
	logic pin_r;
	logic irq_r;
	ctp_pkg::ctp_apb_rsp_t rsp_r;

	logic setup;
	logic wr;
	logic run;
	logic is_pwm;
	logic is_tmr;
	logic tick;
	logic low8_tick;
	logic ovf;
	logic [CNT_W-1:0] period;
	logic [CNT_W-1:0] shadow;
	ctp_pkg::ctp_src_t src;

	// Tick when the low n bits of the divider are all ones
	function automatic logic div_tick(
		input logic [DIV_W-1:0] d,
		input int n
	);
		logic r;
		r = 1'b1;
		for (int i = 0; i < DIV_W; i++) begin
			if (i < n) begin
				r = r & d[i];
			end
		end
		return r;
	endfunction : div_tick

	// Write strobe for one register offset
	function automatic logic wr_at(
		input ctp_pkg::ctp_apb_req_t q,
		input logic w,
		input logic [7:0] off
	);
		return w && (q.paddr == off);
	endfunction : wr_at

	// Bus phase decode
	assign setup = apb_req_i.psel && !apb_req_i.penable;
	assign wr = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite
		&& rsp_r.pready;

	// Mode and run decode from the upper control byte
	assign run = high_ctrl_r[`CTP_RUN_BIT];
	assign is_tmr = high_ctrl_r[`CTP_MODE_LSB +: 3] == `CTP_MODE_TIMER;
	assign is_pwm = high_ctrl_r[`CTP_MODE_LSB +: 3] == `CTP_MODE_PWM;

	// Low byte from the first timer, high byte from the second
	assign period = {per_hi_r, per_lo_r};
	assign shadow = {duty_hi_r, duty_lo_r};
	assign ovf = count_r == {CNT_W{1'b1}};

	// Free-running prescaler on the high clock
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	// Low clock divided by 8
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lowdiv_r <= 3'h0;
		end else if (low_freq_tick_i) begin
			lowdiv_r <= lowdiv_r + 3'h1;
		end
	end
	assign low8_tick = low_freq_tick_i && lowdiv_r == `CTP_LOWDIV_LAST;

	// Source clock select; extra sources only in PWM mode
	always_comb begin
		src = ctp_pkg::ctp_src_t'(low_ctrl_r[`CTP_CLK_LSB +: 3]);
		if (!is_pwm && src > ctp_pkg::CTP_SRC_DIV3) begin
			src = ctp_pkg::CTP_SRC_NONE;
		end
	end

	// Tick of the counting clock
	always_comb begin
		case (src)
			ctp_pkg::CTP_SRC_DIV11: begin
				if (slow_mode_i || prescaler_source_select_i) begin
					tick = low8_tick;
				end else begin
					tick = div_tick(div_r, 11);
				end
			end
			ctp_pkg::CTP_SRC_DIV7: tick = div_tick(div_r, 7);
			ctp_pkg::CTP_SRC_DIV5: tick = div_tick(div_r, 5);
			ctp_pkg::CTP_SRC_DIV3: tick = div_tick(div_r, 3);
			ctp_pkg::CTP_SRC_LOW: tick = low_freq_tick_i;
			ctp_pkg::CTP_SRC_DIV1: tick = div_tick(div_r, 1);
			ctp_pkg::CTP_SRC_FULL: tick = 1'b1;
			default: tick = 1'b0;
		endcase
		if (slow_mode_i && src != ctp_pkg::CTP_SRC_DIV11) begin
			tick = 1'b0;
		end
	end

	// Control registers
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			low_ctrl_r <= `CTP_CTRL_RST;
			high_ctrl_r <= `CTP_CTRL_RST;
		end else begin
			if (wr_at(apb_req_i, wr, `CTP_OFF_LOW_CTRL)) begin
				low_ctrl_r <= apb_req_i.pwdata[7:0];
			end
			if (wr_at(apb_req_i, wr, `CTP_OFF_HIGH_CTRL)) begin
				high_ctrl_r <= apb_req_i.pwdata[7:0];
			end
		end
	end

	// Period compare bytes, used at once with no buffer
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			per_lo_r <= `CTP_CMP_RST;
			per_hi_r <= `CTP_CMP_RST;
		end else begin
			if (wr_at(apb_req_i, wr, `CTP_OFF_PER_LO)) begin
				per_lo_r <= apb_req_i.pwdata[7:0];
			end
			if (wr_at(apb_req_i, wr, `CTP_OFF_PER_HI)) begin
				per_hi_r <= apb_req_i.pwdata[7:0];
			end
		end
	end

	// Duty shadow bytes
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			duty_lo_r <= `CTP_CMP_RST;
			duty_hi_r <= `CTP_CMP_RST;
		end else begin
			if (wr_at(apb_req_i, wr, `CTP_OFF_DUTY_LO)) begin
				duty_lo_r <= apb_req_i.pwdata[7:0];
			end
			if (wr_at(apb_req_i, wr, `CTP_OFF_DUTY_HI)) begin
				duty_hi_r <= apb_req_i.pwdata[7:0];
			end
		end
	end

	// Pending transfer after a duty write while stopped
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			load_pend_r <= 1'b0;
		end else begin
			load_pend_r <= !run && (wr_at(apb_req_i, wr, `CTP_OFF_DUTY_LO)
				|| wr_at(apb_req_i, wr, `CTP_OFF_DUTY_HI));
		end
	end

	// Active duty: loaded at the interrupt or right after a stopped write
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			duty_act_r <= '0;
		end else if (load_pend_r && !run) begin
			duty_act_r <= shadow;
		end else if (run && is_pwm && tick && ovf) begin
			duty_act_r <= shadow;
		end
	end

	// Cascaded 16-bit up-counter, cleared while stopped
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_r <= '0;
		end else if (!run || !(is_tmr || is_pwm)) begin
			count_r <= '0;
		end else if (tick) begin
			if (is_tmr && count_r == period) begin
				count_r <= '0;
			end else if (is_pwm && ovf) begin
				count_r <= '0;
			end else begin
				count_r <= count_r + 1'b1;
			end
		end
	end

	// Interrupt pulse on period match or PWM overflow
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= run && tick && ((is_tmr && count_r == period)
				|| (is_pwm && ovf));
		end
	end

	// Pin holds the inverse of the flip-flop; reset flip-flop is 0
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_r <= 1'b1;
		end else if (wr_at(apb_req_i, wr, `CTP_OFF_HIGH_CTRL) && !run
			&& !apb_req_i.pwdata[`CTP_RUN_BIT]) begin
			pin_r <= !apb_req_i.pwdata[`CTP_INIT_BIT];
		end else if (run && is_pwm && tick) begin
			if (ovf ^ (count_r == duty_act_r)) begin
				pin_r <= !pin_r;
			end
		end
	end

	// Stopping leaves the pin where it was
	assign pwm_out_pin_o = pin_r;
	assign cascade_match_irq_o = irq_r;

	// APB answer: ready the cycle after setup, data captured at setup
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rsp_r <= '0;
		end else begin
			rsp_r.pready <= setup;
			rsp_r.pslverr <= 1'b0;
			rsp_r.prdata <= 32'h0000_0000;
			if (setup) begin
				case (apb_req_i.paddr)
					`CTP_OFF_LOW_CTRL: rsp_r.prdata[7:0] <= low_ctrl_r;
					`CTP_OFF_HIGH_CTRL: rsp_r.prdata[7:0] <= high_ctrl_r;
					`CTP_OFF_PER_LO: rsp_r.prdata[7:0] <= per_lo_r;
					`CTP_OFF_PER_HI: rsp_r.prdata[7:0] <= per_hi_r;
					`CTP_OFF_DUTY_LO: begin
						rsp_r.prdata[7:0] <= duty_act_r[7:0];
					end
					`CTP_OFF_DUTY_HI: begin
						rsp_r.prdata[7:0] <= duty_act_r[15:8];
					end
					`CTP_OFF_COUNT: rsp_r.prdata[15:0] <= count_r;
					default: rsp_r.pslverr <= 1'b1;
				endcase
			end
		end
	end
	assign apb_rsp_o = rsp_r;

endmodule : ctp_timer
`default_nettype wire

// File: verif/ctp_chk.sv
// Purpose: Port-level assertions for the cascaded timer
// Assumes: Zero-wait APB slave, registered outputs
// Notes: Tracks the run bit from APB writes to the upper control word
`include "ctp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ctp_chk (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire ctp_pkg::ctp_apb_req_t apb_req_i,
	input wire ctp_pkg::ctp_apb_rsp_t apb_rsp_o,
	input wire logic cascade_match_irq_o,
	input wire logic pwm_out_pin_o
);
	logic run_r;
	logic hiw;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Upper control write at its access edge
	assign hiw = apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready && apb_req_i.pwrite
		&& apb_req_i.paddr == `CTP_OFF_HIGH_CTRL;
	// Run bit as software last wrote it
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_r <= 1'b0;
		end else if (hiw) begin
			run_r <= apb_req_i.pwdata[`CTP_RUN_BIT];
		end
	end
	// Bus answers, reset levels, stop behaviour
	property p_rdy; apb_req_i.psel && !apb_req_i.penable |=> apb_rsp_o.pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	property p_src; apb_rsp_o.pready |-> $past(apb_req_i.psel && !apb_req_i.penable); endproperty
	a_src: assert property (p_src) else $error("ready without setup");
	property p_err; apb_rsp_o.pslverr |-> apb_rsp_o.pready && apb_rsp_o.prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("bad error answer");
	property p_rst; $rose(rst_n_i) |-> pwm_out_pin_o && !cascade_match_irq_o; endproperty
	a_rst: assert property (p_rst) else $error("bad levels after reset");
	property p_one; cascade_match_irq_o |=> !cascade_match_irq_o; endproperty
	a_one: assert property (p_one) else $error("irq longer than a cycle");
	property p_sirq; !$past(run_r) && !$past(run_r, 2) |-> !cascade_match_irq_o; endproperty
	a_sirq: assert property (p_sirq) else $error("irq while stopped");
	property p_hold;
		!$past(run_r) && !$past(run_r, 2) && !$past(hiw) && !$past(hiw, 2)
			|-> $stable(pwm_out_pin_o);
	endproperty
	a_hold: assert property (p_hold) else $error("pin moved while stopped");
	property p_init;
		hiw && !run_r && !apb_req_i.pwdata[`CTP_RUN_BIT]
			|-> ##2 pwm_out_pin_o != $past(apb_req_i.pwdata[`CTP_INIT_BIT], 2);
	endproperty
	a_init: assert property (p_init) else $error("pin not loaded");
	// Main scenarios reached
	c_irq: cover property (cascade_match_irq_o);
	c_err: cover property (apb_rsp_o.pslverr);
	c_pin: cover property ($fell(pwm_out_pin_o));
endmodule : ctp_chk
`default_nettype wire

// File: verif/ctp_timer_tb.sv
// Purpose: Self-checking bench for the cascaded timer
// Assumes: Zero-wait APB slave, low tick every 4 clocks
// Notes: One undivided PWM frame costs 65536 cycles
`timescale 1ns/1ps
`default_nettype none
module ctp_timer_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sel = 1'b0;
	logic slw = 1'b0;
	logic [1:0] tc = 2'h0;
	logic irq;
	logic pin;
	logic er;
	logic [31:0] rd;
	int mismatches = 0;
	int total_checks = 0;
	ctp_pkg::ctp_apb_req_t rq = '0;
	ctp_pkg::ctp_apb_rsp_t rs;
	ctp_timer dut (
		.core_clk_i(clk),
		.rst_n_i(rst_n),
		.apb_req_i(rq),
		.low_freq_tick_i(tc == 2'h3),
		.prescaler_source_select_i(sel),
		.slow_mode_i(slw),
		.apb_rsp_o(rs),
		.cascade_match_irq_o(irq),
		.pwm_out_pin_o(pin)
	);
	// Clock and low tick
	initial begin
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) tc <= tc + 2'h1;
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done
	task automatic ck(input string s, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %0h got %0h", s, e, g);
		end
	endtask : ck
	// One APB transfer, held until pready
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		rq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
		@(posedge clk);
		rq.penable <= 1'b1;
		@(posedge clk);
		while (rs.pready !== 1'b1) @(posedge clk);
		rd = rs.prdata;
		er = rs.pslverr;
		rq <= '0;
	endtask : bus
	task automatic wirq(input int lim, output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (irq !== 1'b1 && n < lim);
	endtask : wirq
	task automatic regs();
		for (int a = 0; a < 28; a += 4) begin
			bus(1'b0, a[7:0], 8'h00);
			ck("reset reg", 32'h0, rd);
		end
		bus(1'b1, 8'h18, 8'h55);
		bus(1'b0, 8'h18, 8'h00);
		ck("count ro", 32'h0, rd);
		bus(1'b1, 8'h1C, 8'h55);
		ck("unmapped", 1'b1, er);
		ck("pin reset", 1'b1, pin);
	endtask : regs
	// Timer mode: gap between two irqs, none when e is 0
	task automatic tmr(input logic [7:0] lc, input logic [15:0] p, input int e);
		int n;
		bus(1'b1, 8'h00, lc);
		bus(1'b1, 8'h08, p[7:0]);
		bus(1'b1, 8'h0C, p[15:8]);
		bus(1'b1, 8'h04, 8'h04);
		bus(1'b1, 8'h04, 8'h0C);
		wirq(e > 0 ? 2 * e + 9 : 300, n);
		if (e > 0) wirq(e + 9, n);
		ck("irq gap", e > 0 ? e : 300, n);
		bus(1'b1, 8'h04, 8'h04);
	endtask : tmr
	task automatic pwm();
		int n;
		bus(1'b1, 8'h04, 8'h06);
		bus(1'b1, 8'h00, 8'h60);
		bus(1'b1, 8'h10, 8'h10);
		bus(1'b1, 8'h14, 8'h00);
		repeat (3) @(posedge clk);
		bus(1'b0, 8'h10, 8'h00);
		ck("duty stopped", 32'h10, rd);
		bus(1'b1, 8'h04, 8'h0E);
		n = 0;
		while (pin === 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		ck("duty match", 1'b1, n > 15 && n < 24);
		bus(1'b1, 8'h10, 8'h20);
		bus(1'b1, 8'h14, 8'h00);
		bus(1'b0, 8'h10, 8'h00);
		ck("duty shadow", 32'h10, rd);
		wirq(70000, n);
		@(posedge clk);
		ck("overflow pin", 1'b1, pin);
		bus(1'b0, 8'h10, 8'h00);
		ck("duty loaded", 32'h20, rd);
		repeat (40) @(posedge clk);
		bus(1'b1, 8'h04, 8'h06);
		repeat (4) @(posedge clk);
		ck("stop hold", 1'b0, pin);
		bus(1'b1, 8'h04, 8'h86);
		repeat (2) @(posedge clk);
		ck("init one", 1'b0, pin);
		bus(1'b1, 8'h04, 8'h06);
		repeat (2) @(posedge clk);
		ck("init zero", 1'b1, pin);
		bus(1'b1, 8'h04, 8'h86);
		repeat (2) @(posedge clk);
		ck("init reload", 1'b0, pin);
	endtask : pwm
	// Main sequence, timer writes keep the init bit at 0
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		regs();
		tmr(8'h30, 16'h0002, 24);
		tmr(8'h30, 16'h0100, 2056);
		tmr(8'h10, 16'h0000, 128);
		tmr(8'h20, 16'h0001, 64);
		tmr(8'h50, 16'h0001, 0);
		sel <= 1'b1;
		tmr(8'h00, 16'h0001, 64);
		slw <= 1'b1;
		tmr(8'h30, 16'h0001, 0);
		slw <= 1'b0;
		pwm();
		test_done();
	end
	// Watchdog: run needs about 75000 cycles
	initial begin
		#450000;
		mismatches++;
		test_done();
	end
endmodule : ctp_timer_tb
bind ctp_timer ctp_chk u_chk (.core_clk_i, .rst_n_i, .apb_req_i, .apb_rsp_o,
	.cascade_match_irq_o, .pwm_out_pin_o);
`default_nettype wire
